// ---- rtl/blx_exec.sv ----
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/10ps
`include "blx_defs.svh"

// What this block does
// (RULE_01) Bit-set forces chosen bit of addressed file register to one, flags untouched.
// (RULE_02) AND accumulator with file register; result to accumulator or file; zero flag updated.
// (RULE_03) Skip-if-clear: tested bit zero discards next instruction, runs a no-op, two cycles.
// (RULE_04) Skip-if-set: tested bit one discards next instruction, runs a no-op, two cycles.
// (RULE_05) Clear-accumulator loads zero and sets the zero flag.
// (RULE_06) Call first pushes program counter plus one onto the stack top.
// (RULE_07) Call loads counter low byte from literal, upper two from status page, bit 8 zero.
// (RULE_08) Call targets 0 to 255, two cycles, status flags unchanged.
// (RULE_09) Clear-watchdog zeroes the watchdog counter, sets timeout and powerdown flags.
// (RULE_10) Clear-watchdog also clears the prescaler only while it serves the watchdog.
// (RULE_11) Skip-if-clear decodes as 0110, three-bit index, five-bit file address.
// (RULE_12) Skip-if-set decodes as 0111, three-bit index, five-bit file address.
// (RULE_13) The substituted no-op only advances the program counter.
module blx_exec #(
  parameter int FILE_DEPTH = `BLX_FILE_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [10:0] prog_counter,
  output logic [10:0] return_addr,
  output logic stack_push,
  output logic zero_flag,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic watchdog_clear,
  output logic prescaler_clear
);

  blx_pkg::blx_state_t state_q;
  blx_pkg::blx_op_t op;
  blx_pkg::blx_fields_t fld;
  blx_pkg::blx_fwr_t fwr;
  logic [11:0] instr_q;
  logic [7:0] acc_q;
  logic [7:0] status_q;
  logic [7:0] watchdog_q;
  logic [7:0] prescale_q;
  logic [10:0] pc_q;
  logic [10:0] return_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] cur_val;
  logic [31:0] bus_val;
  logic [7:0] file_rd;
  logic [7:0] and_res;
  logic [4:0] rd_addr;
  logic ctrl_wdog_q;
  logic skip_q;
  logic unsup_q;
  logic stack_push_q;
  logic wdog_clear_q;
  logic presc_clear_q;
  logic wait_q;
  logic in_exec;
  logic tested_bit;
  logic skip_take;
  logic bus_wr;

  // Opcode decode, shared by execution and checks
  function automatic blx_pkg::blx_op_t decode_op(input logic [11:0] w);
    blx_pkg::blx_op_t r;
    r = blx_pkg::OP_NONE;
    if (w[11:8] == `BLX_ENC_BIT_SET) r = blx_pkg::OP_BIT_SET;
    else if (w[11:8] == `BLX_ENC_SKIP_CLR) r = blx_pkg::OP_SKIP_CLR; // RULE_11
    else if (w[11:8] == `BLX_ENC_SKIP_SET) r = blx_pkg::OP_SKIP_SET; // RULE_12
    else if (w[11:8] == `BLX_ENC_CALL) r = blx_pkg::OP_CALL;
    else if (w[11:6] == `BLX_ENC_AND) r = blx_pkg::OP_AND;
    else if (w == `BLX_ENC_CLR_ACC) r = blx_pkg::OP_CLR_ACC;
    else if (w == `BLX_ENC_CLR_WDOG) r = blx_pkg::OP_CLR_WDOG;
    return r;
  endfunction : decode_op

  // One-hot mask for a bit index
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    return 8'h01 << idx;
  endfunction : bit_mask

  // Byte-lane merge of a bus write into a register image
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : lane_merge

  // Operand fields: index and address share layout across bit ops
  always_comb begin
    fld.bit_idx = instr_q[7:5]; // RULE_11 RULE_12
    fld.dest = instr_q[5];
    fld.faddr = instr_q[4:0];
    fld.lit = instr_q[7:0];
  end

  assign in_exec = (state_q == blx_pkg::ST_EXEC);
  assign op = decode_op(instr_q);
  assign rd_addr = in_exec ? fld.faddr : avs_address[6:2];
  assign and_res = acc_q & file_rd;
  assign tested_bit = |(file_rd & bit_mask(fld.bit_idx));

  // Skip decision on the tested bit's polarity
  assign skip_take = in_exec && ((op == blx_pkg::OP_SKIP_CLR && !tested_bit) || // RULE_03
                                 (op == blx_pkg::OP_SKIP_SET && tested_bit)); // RULE_04

  // Bus writes other than to the instruction word commit only at the edge the master sees waitrequest low
  assign bus_wr = (state_q == blx_pkg::ST_ACK) && avs_write && avs_address != `BLX_OFF_INSTR;
  assign bus_val = lane_merge(cur_val, avs_writedata, avs_byteenable);

  blx_file_regs #(
    .DEPTH(FILE_DEPTH)
  ) u_file (
    .core_clk(core_clk),
    .rst(rst),
    .wr(fwr),
    .rd_addr(rd_addr),
    .rd_data(file_rd)
  );

  // Register image of the addressed word; unmapped words read zero
  always_comb begin
    cur_val = 32'h0;
    if (avs_address[`BLX_FILE_WIN_BIT]) begin
      cur_val = {24'h0, file_rd};
    end else begin
      case (avs_address)
        `BLX_OFF_INSTR: cur_val = {20'h0, instr_q};
        `BLX_OFF_ACC: cur_val = {24'h0, acc_q};
        `BLX_OFF_STATUS: cur_val = {24'h0, status_q};
        `BLX_OFF_PC: cur_val = {21'h0, pc_q};
        `BLX_OFF_STACK: cur_val = {21'h0, return_addr_q};
        `BLX_OFF_WDOG: cur_val = {16'h0, prescale_q, watchdog_q};
        `BLX_OFF_CTRL: cur_val = {31'h0, ctrl_wdog_q};
        `BLX_OFF_EXSTAT: cur_val = {30'h0, unsup_q, skip_q};
        default: cur_val = 32'h0;
      endcase
    end
  end

  // File write port: bit-set and AND-to-file win over bus, which cannot collide anyway
  always_comb begin
    fwr = '0;
    if (in_exec && op == blx_pkg::OP_BIT_SET) begin
      fwr.we = 1'b1; // RULE_01
      fwr.addr = fld.faddr;
      fwr.data = file_rd | bit_mask(fld.bit_idx);
    end else if (in_exec && op == blx_pkg::OP_AND && fld.dest) begin
      fwr.we = 1'b1; // RULE_02
      fwr.addr = fld.faddr;
      fwr.data = and_res;
    end else if (bus_wr && avs_address[`BLX_FILE_WIN_BIT] && avs_byteenable[0]) begin
      fwr.we = 1'b1;
      fwr.addr = avs_address[6:2];
      fwr.data = avs_writedata[7:0];
    end
  end

  // Bus handshake and instruction sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= blx_pkg::ST_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      case (state_q)
        blx_pkg::ST_IDLE: begin
          if (avs_read || avs_write) begin
            rdata_q <= avs_read ? cur_val : 32'h0;
            if (avs_write && avs_address == `BLX_OFF_INSTR) begin
              state_q <= blx_pkg::ST_EXEC;
            end else begin
              state_q <= blx_pkg::ST_ACK;
              wait_q <= 1'b0;
            end
          end
        end
        blx_pkg::ST_EXEC: begin
          // Taken skips and calls need a second instruction cycle
          if (skip_take || op == blx_pkg::OP_CALL) begin // RULE_03 RULE_04 RULE_08
            state_q <= blx_pkg::ST_SECOND;
          end else begin
            state_q <= blx_pkg::ST_ACK;
            wait_q <= 1'b0;
          end
        end
        blx_pkg::ST_SECOND: begin
          state_q <= blx_pkg::ST_ACK;
          wait_q <= 1'b0;
        end
        blx_pkg::ST_ACK: begin
          state_q <= blx_pkg::ST_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          state_q <= blx_pkg::ST_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // Instruction latch and execution record
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      instr_q <= 12'h000;
      skip_q <= 1'b0;
      unsup_q <= 1'b0;
    end else if (state_q == blx_pkg::ST_IDLE && avs_write && avs_address == `BLX_OFF_INSTR) begin
      instr_q <= avs_writedata[11:0];
    end else if (in_exec) begin
      skip_q <= skip_take;
      unsup_q <= (op == blx_pkg::OP_NONE);
    end
  end

  // Accumulator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_q <= `BLX_RST_ACC;
    end else if (in_exec && op == blx_pkg::OP_AND && !fld.dest) begin
      acc_q <= and_res; // RULE_02
    end else if (in_exec && op == blx_pkg::OP_CLR_ACC) begin
      acc_q <= 8'h00; // RULE_05
    end else if (bus_wr && avs_address == `BLX_OFF_ACC) begin
      acc_q <= bus_val[7:0];
    end
  end

  // Status; bit ops, skips and calls leave it alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_q <= `BLX_RST_STATUS;
    end else if (in_exec && op == blx_pkg::OP_AND) begin
      status_q[`BLX_ST_ZERO] <= (and_res == 8'h00); // RULE_02
    end else if (in_exec && op == blx_pkg::OP_CLR_ACC) begin
      status_q[`BLX_ST_ZERO] <= 1'b1; // RULE_05
    end else if (in_exec && op == blx_pkg::OP_CLR_WDOG) begin
      status_q[`BLX_ST_TMOUT] <= 1'b1; // RULE_09
      status_q[`BLX_ST_PWRDN] <= 1'b1;
    end else if (bus_wr && avs_address == `BLX_OFF_STATUS) begin
      status_q <= bus_val[7:0];
    end
  end

  // Program counter: call target built from literal and page bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pc_q <= `BLX_RST_PC;
    end else if (in_exec && op == blx_pkg::OP_CALL) begin
      pc_q <= {status_q[`BLX_ST_PAGE_HI:`BLX_ST_PAGE_LO], 1'b0, fld.lit}; // RULE_07 RULE_08
    end else if (in_exec || (state_q == blx_pkg::ST_SECOND && skip_q)) begin
      pc_q <= pc_q + 11'h001; // RULE_13
    end else if (bus_wr && avs_address == `BLX_OFF_PC) begin
      pc_q <= bus_val[10:0];
    end
  end

  // Stack top push at the same edge as the jump, from the counter before it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      return_addr_q <= 11'h000;
      stack_push_q <= 1'b0;
    end else begin
      stack_push_q <= in_exec && op == blx_pkg::OP_CALL; // RULE_06
      if (in_exec && op == blx_pkg::OP_CALL) begin
        return_addr_q <= pc_q + 11'h001; // RULE_06
      end
    end
  end

  // Prescaler assignment control
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_wdog_q <= `BLX_RST_CTRL;
    end else if (bus_wr && avs_address == `BLX_OFF_CTRL) begin
      ctrl_wdog_q <= bus_val[0];
    end
  end

  // Watchdog and prescaler counters; a free-running stand-in for the real timebase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      watchdog_q <= 8'h00;
      prescale_q <= 8'h00;
    end else if (in_exec && op == blx_pkg::OP_CLR_WDOG) begin
      watchdog_q <= 8'h00; // RULE_09
      prescale_q <= ctrl_wdog_q ? 8'h00 : prescale_q + 8'h01; // RULE_10
    end else begin
      prescale_q <= prescale_q + 8'h01;
      if (!ctrl_wdog_q || prescale_q == 8'hff) begin
        watchdog_q <= watchdog_q + 8'h01;
      end
    end
  end

  // Clear strobes for the neighbouring timer logic
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdog_clear_q <= 1'b0;
      presc_clear_q <= 1'b0;
    end else begin
      wdog_clear_q <= in_exec && op == blx_pkg::OP_CLR_WDOG; // RULE_09
      presc_clear_q <= in_exec && op == blx_pkg::OP_CLR_WDOG && ctrl_wdog_q; // RULE_10
    end
  end

  // Outputs, all from flops
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign prog_counter = pc_q;
  assign return_addr = return_addr_q;
  assign stack_push = stack_push_q;
  assign zero_flag = status_q[`BLX_ST_ZERO];
  assign timeout_flag = status_q[`BLX_ST_TMOUT];
  assign powerdown_flag = status_q[`BLX_ST_PWRDN];
  assign watchdog_clear = wdog_clear_q;
  assign prescaler_clear = presc_clear_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_bit_set_quiet: assert property (in_exec && op == blx_pkg::OP_BIT_SET |-> // RULE_01
      fwr.we && (fwr.data & bit_mask(fld.bit_idx)) != 8'h00 ##1 status_q == $past(status_q) && acc_q == $past(acc_q))
    else $error("bit set changed flags or missed bit");
  a_and_result: assert property (in_exec && op == blx_pkg::OP_AND && !fld.dest |=> // RULE_02
      acc_q == ($past(acc_q) & $past(file_rd)) && status_q[`BLX_ST_ZERO] == (acc_q == 8'h00))
    else $error("and to accumulator wrong");
  a_skip_clear: assert property (in_exec && op == blx_pkg::OP_SKIP_CLR && !tested_bit |=> // RULE_03
      state_q == blx_pkg::ST_SECOND ##1 pc_q == $past(pc_q, 2) + 11'h002 && status_q == $past(status_q, 2))
    else $error("skip if clear not two cycles");
  a_skip_set: assert property (in_exec && op == blx_pkg::OP_SKIP_SET |=> // RULE_04
      (state_q == blx_pkg::ST_SECOND) == $past(tested_bit))
    else $error("skip if set polarity wrong");
  a_clear_acc: assert property (in_exec && op == blx_pkg::OP_CLR_ACC |=> // RULE_05
      acc_q == 8'h00 && zero_flag)
    else $error("clear accumulator wrong");
  a_call_push: assert property (in_exec && op == blx_pkg::OP_CALL |=> // RULE_06
      stack_push && return_addr == $past(pc_q) + 11'h001)
    else $error("call push wrong");
  a_call_target: assert property (in_exec && op == blx_pkg::OP_CALL |=> // RULE_07
      prog_counter == {$past(status_q[`BLX_ST_PAGE_HI:`BLX_ST_PAGE_LO]), 1'b0, $past(fld.lit)})
    else $error("call target wrong");
  a_call_cycles: assert property (in_exec && op == blx_pkg::OP_CALL |=> // RULE_08
      state_q == blx_pkg::ST_SECOND ##1 state_q == blx_pkg::ST_ACK && status_q == $past(status_q, 2))
    else $error("call not two cycles or flags moved");
  a_wdog_clear: assert property (in_exec && op == blx_pkg::OP_CLR_WDOG |=> // RULE_09
      watchdog_q == 8'h00 && timeout_flag && powerdown_flag && watchdog_clear)
    else $error("watchdog clear wrong");
  a_presc_assign: assert property (in_exec && op == blx_pkg::OP_CLR_WDOG |=> // RULE_10
      prescaler_clear == $past(ctrl_wdog_q) && (prescale_q == 8'h00) == $past(ctrl_wdog_q || prescale_q == 8'hff))
    else $error("prescaler clear ignores assignment");
  a_nop_quiet: assert property (state_q == blx_pkg::ST_SECOND |=> // RULE_13
      acc_q == $past(acc_q) && status_q == $past(status_q) && !stack_push && return_addr == $past(return_addr))
    else $error("substituted no-op had side effect");
  a_bus_answer: assert property ((avs_read || avs_write) && state_q == blx_pkg::ST_IDLE |-> ##[1:3] !avs_waitrequest)
    else $error("bus answer late");

  c_skip_taken: cover property (skip_take ##1 state_q == blx_pkg::ST_SECOND);
  c_call_done: cover property (in_exec && op == blx_pkg::OP_CALL ##2 !avs_waitrequest);
  c_presc_clear: cover property (prescaler_clear);
  c_file_read: cover property (avs_read && avs_address[`BLX_FILE_WIN_BIT] && !avs_waitrequest);

endmodule : blx_exec

// ---- rtl/blx_defs.svh ----
`ifndef BLX_DEFS_SVH
`define BLX_DEFS_SVH

// Register byte offsets on the bus
`define BLX_OFF_INSTR 8'h00
`define BLX_OFF_ACC 8'h04
`define BLX_OFF_STATUS 8'h08
`define BLX_OFF_PC 8'h0c
`define BLX_OFF_STACK 8'h10
`define BLX_OFF_WDOG 8'h14
`define BLX_OFF_CTRL 8'h18
`define BLX_OFF_EXSTAT 8'h1c
`define BLX_FILE_WIN_BIT 7

// Instruction encodings
`define BLX_ENC_BIT_SET 4'h5
`define BLX_ENC_SKIP_CLR 4'h6
`define BLX_ENC_SKIP_SET 4'h7
`define BLX_ENC_CALL 4'h9
`define BLX_ENC_AND 6'h05
`define BLX_ENC_CLR_ACC 12'h040
`define BLX_ENC_CLR_WDOG 12'h004

// Status field positions
`define BLX_ST_ZERO 2
`define BLX_ST_PWRDN 3
`define BLX_ST_TMOUT 4
`define BLX_ST_PAGE_LO 5
`define BLX_ST_PAGE_HI 6

// Reset values
`define BLX_RST_STATUS 8'h18
`define BLX_RST_CTRL 1'b1
`define BLX_RST_ACC 8'h00
`define BLX_RST_PC 11'h000

// Sizes
`define BLX_FILE_DEPTH 32
`define BLX_FILE_WIDTH 8

`endif

// ---- rtl/blx_pkg.sv ----
package blx_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_SECOND = 4'b0100,
    ST_ACK = 4'b1000
  } blx_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_BIT_SET = 3'h1,
    OP_AND = 3'h2,
    OP_SKIP_CLR = 3'h3,
    OP_SKIP_SET = 3'h4,
    OP_CLR_ACC = 3'h5,
    OP_CALL = 3'h6,
    OP_CLR_WDOG = 3'h7
  } blx_op_t;

  typedef struct packed {
    logic [2:0] bit_idx;
    logic dest;
    logic [4:0] faddr;
    logic [7:0] lit;
  } blx_fields_t;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } blx_fwr_t;

endpackage : blx_pkg

// ---- rtl/blx_file_regs.sv ----
`timescale 1ns/10ps
`include "blx_defs.svh"

module blx_file_regs #(
  parameter int DEPTH = `BLX_FILE_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire blx_pkg::blx_fwr_t wr,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem_q [DEPTH];

  // Five address bits cannot reach more than 32 entries
  generate
    if (DEPTH < 1 || DEPTH > 32) begin : g_bad_depth
      $error("blx_file_regs: DEPTH must be 1 to 32");
    end
  endgenerate

  // One flop group per entry; entries beyond DEPTH read as zero
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          mem_q[i] <= 8'h00;
        end else if (wr.we && wr.addr == 5'(i)) begin
          mem_q[i] <= wr.data;
        end
      end
    end
  endgenerate

  // Asynchronous read so an instruction sees its operand in its own cycle
  always_comb begin
    rd_data = 8'h00;
    if (32'(rd_addr) < DEPTH) begin
      rd_data = mem_q[rd_addr];
    end
  end

endmodule : blx_file_regs

// ---- verification/test_blx_exec.sv ----
`timescale 1ns/10ps
`include "blx_defs.svh"

module test_blx_exec;
  logic core_clk;
  logic rst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [10:0] prog_counter;
  logic [10:0] return_addr;
  logic stack_push;
  logic zero_flag;
  logic timeout_flag;
  logic powerdown_flag;
  logic watchdog_clear;
  logic prescaler_clear;
  int failures = 0;
  int tests_run = 0;
  int push_cnt = 0;
  int wd_cnt = 0;
  int ps_cnt = 0;
  // Reference model of the core state
  logic [7:0] m_file [32];
  logic [7:0] m_acc;
  logic [7:0] m_st;
  logic [10:0] m_pc;
  logic [7:0] r;
  logic [31:0] q;
  int n;
  int f;
  int k;
  int base;
  int taken;

  blx_exec dut (
    .core_clk(core_clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .prog_counter(prog_counter),
    .return_addr(return_addr),
    .stack_push(stack_push),
    .zero_flag(zero_flag),
    .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag),
    .watchdog_clear(watchdog_clear),
    .prescaler_clear(prescaler_clear)
  );

  // Free running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Strobes are one cycle wide, so counting edges gives exact pulse counts
  always @(posedge core_clk) begin
    if (stack_push === 1'b1) push_cnt++;
    if (watchdog_clear === 1'b1) wd_cnt++;
    if (prescaler_clear === 1'b1) ps_cnt++;
  end

  function automatic logic [7:0] file_addr(input int idx);
    return 8'(128 + 4 * idx);
  endfunction : file_addr

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One bus transfer; held until waitrequest is sampled low, edges counted
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
                     output int cyc);
    @(posedge core_clk);
    avs_write <= w;
    avs_read <= ~w;
    avs_address <= a;
    avs_writedata <= d;
    cyc = 0;
    do begin
      @(posedge core_clk);
      cyc++;
    end while (avs_waitrequest !== 1'b0);
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q, n);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0, q, n);
    chk(name, exp, q);
  endtask : rd

  task automatic exec(input logic [11:0] instr, input int cyc);
    bus(1'b1, `BLX_OFF_INSTR, {20'h0, instr}, q, n);
    chk("cycles", cyc, n);
  endtask : exec

  // Accumulator, status, counter and flag outputs against the model
  task automatic check_state();
    rd(`BLX_OFF_ACC, {24'h0, m_acc}, "acc");
    rd(`BLX_OFF_STATUS, {24'h0, m_st}, "status");
    rd(`BLX_OFF_PC, {21'h0, m_pc}, "pc");
    chk("pc_port", {21'h0, m_pc}, {21'h0, prog_counter});
    chk("flags", {29'h0, m_st[2], m_st[3], m_st[4]}, {29'h0, zero_flag, powerdown_flag, timeout_flag});
  endtask : check_state

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Whole run needs under a thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    void'($urandom(88890));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    m_acc = `BLX_RST_ACC;
    m_st = `BLX_RST_STATUS;
    m_pc = `BLX_RST_PC;
    check_state();
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0, "unmapped");
    $display("test reset done");
    // Random file contents and accumulator
    for (int i = 0; i < 32; i++) begin
      m_file[i] = 8'($urandom);
      wr(file_addr(i), {24'h0, m_file[i]});
    end
    m_acc = 8'($urandom);
    wr(`BLX_OFF_ACC, {24'h0, m_acc});
    // Every bit index, edge addresses 0 and 31 included
    for (int b = 0; b < 8; b++) begin
      f = (b == 0) ? 0 : (b == 7) ? 31 : $urandom_range(0, 31);
      m_file[f][b] = 1'b1;
      m_pc++;
      exec({4'h5, b[2:0], f[4:0]}, 3);
      rd(file_addr(f), {24'h0, m_file[f]}, "file_bit_set");
      check_state();
    end
    $display("test bit set done");
    // Both destinations; pass 2 forces a zero result
    for (int i = 0; i < 4; i++) begin
      f = $urandom_range(0, 31);
      if (i == 2) begin
        m_acc = ~m_file[f];
        wr(`BLX_OFF_ACC, {24'h0, m_acc});
      end
      r = m_acc & m_file[f];
      if (i[0]) m_file[f] = r;
      else m_acc = r;
      m_st[2] = (r == 8'h00);
      m_pc++;
      exec({6'h05, i[0], f[4:0]}, 3);
      rd(file_addr(f), {24'h0, m_file[f]}, "file_and");
      check_state();
    end
    $display("test and done");
    // Both skip kinds against both bit values
    for (int i = 0; i < 8; i++) begin
      f = $urandom_range(0, 31);
      k = $urandom_range(0, 7);
      m_file[f][k] = i[1];
      wr(file_addr(f), {24'h0, m_file[f]});
      taken = int'(i[0] == i[1]);
      m_pc = m_pc + 11'((taken != 0) ? 2 : 1);
      exec({3'b011, i[0], k[2:0], f[4:0]}, (taken != 0) ? 4 : 3);
      rd(`BLX_OFF_EXSTAT, taken, "skip_record");
      check_state();
    end
    $display("test skip done");
    m_acc = 8'($urandom) | 8'h01;
    wr(`BLX_OFF_ACC, {24'h0, m_acc});
    m_acc = 8'h00;
    m_st[2] = 1'b1;
    m_pc++;
    exec(`BLX_ENC_CLR_ACC, 3);
    check_state();
    $display("test clear acc done");
    // Unsupported word runs as a plain no-op and is recorded
    m_pc++;
    exec(12'h000, 3);
    rd(`BLX_OFF_EXSTAT, 32'h2, "unsupported");
    check_state();
    $display("test unsupported done");
    // Calls from a counter with bit 8 set, every page, targets 0 and 255
    for (int i = 0; i < 4; i++) begin
      k = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(0, 255);
      m_st[6:5] = i[1:0];
      wr(`BLX_OFF_STATUS, {24'h0, m_st});
      m_pc = {3'b001, 8'($urandom)};
      wr(`BLX_OFF_PC, {21'h0, m_pc});
      base = push_cnt;
      exec({4'h9, k[7:0]}, 4);
      @(posedge core_clk);
      chk("return_addr", m_pc + 1, {21'h0, return_addr});
      chk("push_count", base + 1, push_cnt);
      rd(`BLX_OFF_STACK, {21'h0, m_pc + 11'h001}, "stack_reg");
      m_pc = {i[1:0], 1'b0, k[7:0]};
      check_state();
    end
    $display("test call done");
    // Prescaler on tick counter, then on watchdog
    for (int c = 0; c < 2; c++) begin
      wr(`BLX_OFF_CTRL, c);
      m_st[4:3] = 2'b00;
      wr(`BLX_OFF_STATUS, {24'h0, m_st});
      base = wd_cnt;
      k = ps_cnt;
      m_st[4:3] = 2'b11;
      m_pc++;
      exec(`BLX_ENC_CLR_WDOG, 3);
      bus(1'b0, `BLX_OFF_WDOG, 32'h0, q, n);
      if (c == 1) chk("watchdog", 32'h0, {24'h0, q[7:0]});
      if (c == 1) chk("prescaler_low", 32'h1, {31'h0, q[15:8] < 8'h10});
      @(posedge core_clk);
      chk("wd_pulses", base + 1, wd_cnt);
      chk("ps_pulses", k + c, ps_cnt);
      check_state();
    end
    $display("test clear watchdog done");
    finish_test();
  end
endmodule : test_blx_exec
